// ==== ssa_command_logic.sv ====
// Command handling for status, fault mask, auxiliary outputs, restore
// defaults and calibration mode, reached as an Avalon-MM slave.
// Assumes status_live and local_mode are synchronous to clock and
// that a front end has already turned each text line into commands.
//
// Notes on behaviour
// - Accumulated status latches every bit seen true
// - Accumulated and live status share bit layout
// - Accumulated status query clears after reporting
// - Query answer is keyword plus weight sum
// - Live status query returns present conditions
// - Fault query returns enabled faulted conditions
// - Mask stops named conditions setting faults
// - Condition enable lets named conditions set faults
// - Enabled conditions query reports unmasked conditions
// - First aux output follows argument, active low
// - First aux query returns programmed value
// - Second aux output follows argument, active low
// - Second aux query returns programmed value
// - Restore command returns settings to defaults
// - Restore in local mode waits for remote
// - Restore command clears whole fault register
// - Restore leaves calibration flag unchanged
// - Calibration command on enters calibration mode
// - Calibration query returns zero or one
// - Commands run strictly in arrival order
// - Any fault bit asserts fault line
// - Fault query clears reported bits and line
//
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
module ssa_command_logic
    import ssa_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              reset_n,
    input  wire logic [3:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic [STAT_W-1:0] status_live,
    input  wire logic              local_mode,
    output logic                   aux_one_n,
    output logic                   aux_two_n,
    output logic                   fault_line_n,
    output logic                   calibration_mode_flag,
    output logic                   defaults_apply
);

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    ssa_bus_type       bus_r;
    ssa_bus_type       bus_nxt;
    logic              waitrequest_r;
    logic [31:0]       readdata_r;
    logic [STAT_W-1:0] acc_r;
    logic [STAT_W-1:0] acc_nxt;
    logic [STAT_W-1:0] fault_r;
    logic [STAT_W-1:0] fault_nxt;
    logic [STAT_W-1:0] enable_r;
    logic [STAT_W-1:0] enable_nxt;
    logic              aux_one_r;
    logic              aux_one_nxt;
    logic              aux_two_r;
    logic              aux_two_nxt;
    logic              cal_r;
    logic              cal_nxt;
    logic              aux_one_n_r;
    logic              aux_two_n_r;
    logic              fault_n_r;
    logic              pend_r;
    logic              local_q_r;
    logic              apply_r;
    ssa_resp_type      resp_r;
    ssa_resp_type      resp_nxt;

    ssa_cmd_type       cmd;
    logic              exec;
    logic              acc_clr;
    logic [STAT_W-1:0] fault_clr;
    logic              restore;
    logic              apply;

    assign cmd  = ssa_cmd_type'(avs_writedata);
    // in order
    // One command per completed full-word write to OFS_CMD, so commands run as they arrive
    assign exec = (bus_r == BUS_ACK) && avs_write
                  && (avs_address == OFS_CMD)
                  && (avs_byteenable == BE_ALL);

    // -----------------------------------------------------------------
    // Bus handshake
    // -----------------------------------------------------------------
    // Every access takes one wait cycle so read data come from a flop
    always_comb begin
        case (bus_r)
            BUS_IDLE: bus_nxt = (avs_read || avs_write) ? BUS_ACK : BUS_IDLE;
            BUS_ACK:  bus_nxt = BUS_IDLE;
            default:  bus_nxt = BUS_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bus_r         <= BUS_IDLE;
            waitrequest_r <= 1'b1;
        end else begin
            bus_r         <= bus_nxt;
            waitrequest_r <= (bus_nxt != BUS_ACK);
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            readdata_r <= WORD_ZERO;
        end else if (bus_r == BUS_IDLE && avs_read) begin
            case (avs_address)
                OFS_RESP:  readdata_r <= resp_r;
                OFS_STATE: readdata_r <= ssa_state_type'({
                               26'h0, pend_r, local_mode, ~fault_n_r,
                               cal_r, aux_two_r, aux_one_r});
                default:   readdata_r <= WORD_ZERO;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Command decode
    // -----------------------------------------------------------------
    always_comb begin
        acc_clr     = 1'b0;
        fault_clr   = STAT_ZERO;
        restore     = 1'b0;
        enable_nxt  = enable_r;
        aux_one_nxt = aux_one_r;
        aux_two_nxt = aux_two_r;
        cal_nxt     = cal_r;
        resp_nxt    = resp_r;
        if (exec) begin
            resp_nxt       = '0;
            resp_nxt.op    = cmd.op;
            case (cmd.op)
                OP_ACC_STS_Q: begin
                    resp_nxt.value = acc_r | status_live;
                    acc_clr        = 1'b1;
                end
                OP_LIVE_STS_Q: resp_nxt.value = status_live;
                OP_FAULT_Q: begin
                    resp_nxt.value = fault_r;
                    fault_clr      = fault_r;
                end
                OP_MASK:      enable_nxt = enable_r & ~cmd.arg;
                OP_COND_EN:   enable_nxt = enable_r | cmd.arg;
                OP_ENABLED_Q: resp_nxt.value = enable_r;
                OP_AUX1_SET: begin
                    if (ssa_arg_ok(cmd.arg)) aux_one_nxt = cmd.arg[0];
                    else resp_nxt.err = 1'b1;
                end
                OP_AUX1_Q:    resp_nxt.value = {15'h0, aux_one_r};
                OP_AUX2_SET: begin
                    if (ssa_arg_ok(cmd.arg)) aux_two_nxt = cmd.arg[0];
                    else resp_nxt.err = 1'b1;
                end
                OP_AUX2_Q:    resp_nxt.value = {15'h0, aux_two_r};
                OP_RESTORE: begin
                    restore   = 1'b1;
                    fault_clr = STAT_ONES;
                end
                OP_CAL_SET: begin
                    if (ssa_arg_ok(cmd.arg)) cal_nxt = cmd.arg[0];
                    else resp_nxt.err = 1'b1;
                end
                OP_CAL_Q:     resp_nxt.value = {15'h0, cal_r};
                default:      resp_nxt.err = 1'b1;
            endcase
        end
        // calibration kept
        // Defaults win over a setting written in the same cycle
        if (apply) begin
            enable_nxt  = ENABLE_RESET;
            aux_one_nxt = AUX_RESET;
            aux_two_nxt = AUX_RESET;
        end
    end

    // -----------------------------------------------------------------
    // Restore defaults, deferred while local
    // -----------------------------------------------------------------
    // defer in local
    assign apply = (restore && !local_mode)
                   || (pend_r && local_q_r && !local_mode);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pend_r    <= 1'b0;
            local_q_r <= 1'b0;
            apply_r   <= 1'b0;
        end else begin
            local_q_r <= local_mode;
            apply_r   <= apply;
            if (restore && local_mode) pend_r <= 1'b1;
            else if (apply) pend_r <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // Status, fault and mask registers
    // -----------------------------------------------------------------
    // latch seen bits
    // Live bits are ORed in after the clear so nothing is lost
    assign acc_nxt   = (acc_clr ? STAT_ZERO : acc_r) | status_live;
    // Set wins over a clear in the same cycle
    assign fault_nxt = (fault_r & ~fault_clr) | (status_live & enable_r);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            acc_r <= STAT_ZERO;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            fault_r   <= STAT_ZERO;
            fault_n_r <= 1'b1;
        end else begin
            fault_r   <= fault_nxt;
            fault_n_r <= (fault_nxt == STAT_ZERO);
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            enable_r <= ENABLE_RESET;
        end else begin
            enable_r <= enable_nxt;
        end
    end

    // -----------------------------------------------------------------
    // Aux outputs, calibration flag, response
    // -----------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            aux_one_r   <= AUX_RESET;
            aux_two_r   <= AUX_RESET;
            aux_one_n_r <= ~AUX_RESET;
            aux_two_n_r <= ~AUX_RESET;
        end else begin
            aux_one_r   <= aux_one_nxt;
            aux_two_r   <= aux_two_nxt;
            aux_one_n_r <= ~aux_one_nxt;
            aux_two_n_r <= ~aux_two_nxt;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cal_r <= CAL_RESET;
        end else begin
            cal_r <= cal_nxt;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            resp_r <= '0;
        end else begin
            resp_r <= resp_nxt;
        end
    end

    assign avs_readdata          = readdata_r;
    assign avs_waitrequest       = waitrequest_r;
    assign aux_one_n             = aux_one_n_r;
    assign aux_two_n             = aux_two_n_r;
    assign fault_line_n          = fault_n_r;
    assign calibration_mode_flag = cal_r;
    assign defaults_apply        = apply_r;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    AST_ACC_LATCH: assert property (
        (status_live != STAT_ZERO) |=>
            ((acc_r & $past(status_live)) == $past(status_live)))
        else $error("accumulated status lost a live bit");

    AST_ACC_CLEAR: assert property (
        (exec && cmd.op == OP_ACC_STS_Q) |=>
            (acc_r == $past(status_live)))
        else $error("accumulated status not cleared by query");

    AST_ACC_REPORT: assert property (
        (exec && cmd.op == OP_ACC_STS_Q) |=>
            (resp_r.value == $past(acc_r | status_live))
            && (resp_r.op == OP_ACC_STS_Q))
        else $error("accumulated status answer wrong");

    AST_LIVE_REPORT: assert property (
        (exec && cmd.op == OP_LIVE_STS_Q) |=>
            (resp_r.value == $past(status_live)))
        else $error("live status answer wrong");

    AST_FAULT_LINE: assert property (
        fault_n_r == (fault_r == STAT_ZERO))
        else $error("fault line disagrees with fault register");

    AST_FAULT_QUERY: assert property (
        (exec && cmd.op == OP_FAULT_Q) |=>
            (resp_r.value == $past(fault_r))
            && (fault_r == ($past(status_live) & $past(enable_r))))
        else $error("fault query did not report and clear");

    AST_MASK: assert property (
        (exec && cmd.op == OP_MASK && !apply) |=>
            ((enable_r & $past(cmd.arg)) == STAT_ZERO))
        else $error("mask left a condition enabled");

    AST_AUX_ONE: assert property (
        (exec && cmd.op == OP_AUX1_SET && ssa_arg_ok(cmd.arg) && !apply)
            |=> (aux_one_r == $past(cmd.arg[0]))
                && (aux_one_n_r == !$past(cmd.arg[0])))
        else $error("first aux output did not follow argument");

    AST_CAL_KEPT: assert property (
        (exec && cmd.op == OP_RESTORE) |=> $stable(cal_r))
        else $error("restore changed calibration flag");

    AST_BAD_ARG: assert property (
        (exec && cmd.op == OP_CAL_SET && !ssa_arg_ok(cmd.arg)) |=>
            $stable(cal_r) && resp_r.err)
        else $error("bad calibration argument accepted");

    AST_DEFER: assert property (
        (exec && cmd.op == OP_RESTORE && local_mode) |=>
            pend_r && !defaults_apply)
        else $error("restore in local mode applied at once");

    AST_WAIT: assert property (
        ((avs_read || avs_write) && waitrequest_r) |=> !waitrequest_r)
        else $error("access not answered after one wait cycle");

endmodule // ssa_command_logic

// ==== ssa_host_model.sv ====
// Host side model: issues Avalon-MM accesses to the command block.
// Assumes one clock; the bench starts every access by a task call.
module ssa_host_model
    import ssa_pkg::*;
(
    input  wire logic        clock,
    output logic [3:0]       avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic [31:0]      avs_writedata,
    output logic [3:0]       avs_byteenable,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    timeunit 1ns;
    timeprecision 1ns;

    int hang_count = 0;

    initial begin
        avs_address    = 4'h0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0000_0000;
        avs_byteenable = 4'h0;
    end

    task automatic access(input logic wr, input logic [3:0] addr,
                          input logic [31:0] wd, input logic [3:0] be,
                          output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clock);
        avs_address    <= addr;
        avs_write      <= wr;
        avs_read       <= ~wr;
        avs_writedata  <= wd;
        avs_byteenable <= be;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 32);
        if (n >= 32) hang_count++;
        rd = avs_readdata;
        avs_read       <= 1'b0;
        avs_write      <= 1'b0;
        // Released address and data lines show their inverse, not the last value
        avs_address    <= ~addr;
        avs_writedata  <= ~wd;
    endtask

    // command word, then its answer, in order
    task automatic command(input ssa_op_type op, input logic [15:0] arg,
                           output ssa_resp_type resp);
        logic [31:0] rd;
        access(1'b1, OFS_CMD, {arg, 12'h000, op}, BE_ALL, rd);
        access(1'b0, OFS_RESP, WORD_ZERO, BE_ALL, rd);
        resp = rd;
    endtask
endmodule // ssa_host_model

// ==== ssa_pkg.sv ====
// Constants, command codes and carrier types for the supply status,
// fault mask, auxiliary output and calibration mode command block.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package ssa_pkg;

    localparam int STAT_W = 16;

    // -----------------------------------------------------------------
    // Register offsets (byte addresses)
    // -----------------------------------------------------------------
    localparam logic [3:0] OFS_CMD   = 4'h0;
    localparam logic [3:0] OFS_RESP  = 4'h4;
    localparam logic [3:0] OFS_STATE = 4'h8;
    localparam logic [3:0] BE_ALL    = 4'hF;

    // -----------------------------------------------------------------
    // Arguments and power-on values
    // -----------------------------------------------------------------
    localparam logic [15:0]       ARG_OFF      = 16'h0000;
    localparam logic [15:0]       ARG_ON       = 16'h0001;
    localparam logic [STAT_W-1:0] ENABLE_RESET = 16'h0000;
    localparam logic [STAT_W-1:0] STAT_ZERO    = 16'h0000;
    localparam logic [STAT_W-1:0] STAT_ONES    = 16'hFFFF;
    localparam logic              AUX_RESET    = 1'b0;
    localparam logic              CAL_RESET    = 1'b0;
    localparam logic [31:0]       WORD_ZERO    = 32'h0000_0000;

    // -----------------------------------------------------------------
    // Command codes
    // -----------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NONE      = 4'h0,
        OP_ACC_STS_Q = 4'h1,
        OP_LIVE_STS_Q = 4'h2,
        OP_FAULT_Q   = 4'h3,
        OP_MASK      = 4'h4,
        OP_COND_EN   = 4'h5,
        OP_ENABLED_Q = 4'h6,
        OP_AUX1_SET  = 4'h7,
        OP_AUX1_Q    = 4'h8,
        OP_AUX2_SET  = 4'h9,
        OP_AUX2_Q    = 4'hA,
        OP_RESTORE   = 4'hB,
        OP_CAL_SET   = 4'hC,
        OP_CAL_Q     = 4'hD
    } ssa_op_type;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK  = 2'b01
    } ssa_bus_type;

    // -----------------------------------------------------------------
    // Carriers
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] arg;
        logic [11:0] unused;
        ssa_op_type  op;
    } ssa_cmd_type;

    typedef struct packed {
        logic [15:0] value;
        logic [6:0]  unused_hi;
        logic        err;
        logic [3:0]  unused_lo;
        ssa_op_type  op;
    } ssa_resp_type;

    typedef struct packed {
        logic [25:0] unused;
        logic        pending;
        logic        local_mode;
        logic        fault_active;
        logic        cal_mode;
        logic        aux_two;
        logic        aux_one;
    } ssa_state_type;

    function automatic logic ssa_arg_ok(input logic [15:0] arg);
        return (arg == ARG_OFF) || (arg == ARG_ON);
    endfunction

endpackage : ssa_pkg

// ==== testbench.sv ====
// Self-checking bench for the command block.
// Assumes the host model drives the bus; the bench drives the
// condition inputs and local mode and watches the output pins.
module testbench
    import ssa_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic              clock;
    logic              reset_n;
    logic [3:0]        avs_address;
    logic              avs_read;
    logic              avs_write;
    logic [31:0]       avs_writedata;
    logic [3:0]        avs_byteenable;
    logic [31:0]       avs_readdata;
    logic              avs_waitrequest;
    logic [STAT_W-1:0] status_live;
    logic              local_mode;
    logic              aux_one_n;
    logic              aux_two_n;
    logic              fault_line_n;
    logic              calibration_mode_flag;
    logic              defaults_apply;
    int                miscompares = 0;
    int                num_checks  = 0;
    int                apply_count = 0;

    ssa_host_model host (.clock(clock), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    ssa_command_logic dut (.clock(clock), .reset_n(reset_n),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .status_live(status_live),
        .local_mode(local_mode), .aux_one_n(aux_one_n),
        .aux_two_n(aux_two_n), .fault_line_n(fault_line_n),
        .calibration_mode_flag(calibration_mode_flag),
        .defaults_apply(defaults_apply));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    always @(posedge clock) begin
        if (defaults_apply === 1'b1) apply_count++;
    end

    // -----------------------------------------------------------------
    // Shared helpers
    // -----------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic query(input ssa_op_type op, input logic [15:0] exp);
        ssa_resp_type r;
        host.command(op, 16'h0000, r);
        check(op.name(), {16'h0000, exp}, {16'h0000, r.value});
        check("query err", 32'h0, {31'h0, r.err});
    endtask

    task automatic setc(input ssa_op_type op, input logic [15:0] arg,
                        input logic exp_err);
        ssa_resp_type r;
        host.command(op, arg, r);
        check({op.name(), " err"}, {31'h0, exp_err}, {31'h0, r.err});
    endtask

    task automatic pulse_live(input logic [STAT_W-1:0] v);
        status_live <= v;
        repeat (3) @(posedge clock);
        status_live <= STAT_ZERO;
        repeat (2) @(posedge clock);
    endtask

    function automatic logic aux_pin(int i);
        return (i == 0) ? aux_one_n : aux_two_n;
    endfunction

    // -----------------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------------
    task automatic t_reset();
        check("aux1 pin", 32'h1, {31'h0, aux_one_n});
        check("aux2 pin", 32'h1, {31'h0, aux_two_n});
        check("fault pin", 32'h1, {31'h0, fault_line_n});
        check("cal flag", 32'h0, {31'h0, calibration_mode_flag});
        query(OP_ENABLED_Q, 16'h0000);
        query(OP_AUX1_Q, 16'h0000);
        query(OP_AUX2_Q, 16'h0000);
        query(OP_CAL_Q, 16'h0000);
        $display("test reset done");
    endtask

    task automatic t_aux();
        ssa_op_type s;
        ssa_op_type q;
        for (int i = 0; i < 2; i++) begin
            s = (i == 0) ? OP_AUX1_SET : OP_AUX2_SET;
            q = (i == 0) ? OP_AUX1_Q : OP_AUX2_Q;
            setc(s, ARG_ON, 1'b0);
            check("aux pin on", 32'h0, {31'h0, aux_pin(i)});
            query(q, 16'h0001);
            setc(s, 16'h0005, 1'b1);
            check("aux pin kept", 32'h0, {31'h0, aux_pin(i)});
            query(q, 16'h0001);
            setc(s, ARG_OFF, 1'b0);
            check("aux pin off", 32'h1, {31'h0, aux_pin(i)});
            query(q, 16'h0000);
        end
        $display("test aux done");
    endtask

    task automatic t_cal();
        setc(OP_CAL_SET, ARG_ON, 1'b0);
        check("cal on", 32'h1, {31'h0, calibration_mode_flag});
        query(OP_CAL_Q, 16'h0001);
        setc(OP_CAL_SET, 16'h0002, 1'b1);
        check("cal kept", 32'h1, {31'h0, calibration_mode_flag});
        $display("test cal done");
    endtask

    task automatic t_status();
        status_live <= 16'h0005;
        repeat (3) @(posedge clock);
        status_live <= 16'h0002;
        repeat (2) @(posedge clock);
        query(OP_LIVE_STS_Q, 16'h0002);
        query(OP_ACC_STS_Q, 16'h0007);
        status_live <= STAT_ZERO;
        repeat (2) @(posedge clock);
        query(OP_ACC_STS_Q, 16'h0002);
        query(OP_ACC_STS_Q, 16'h0000);
        query(OP_LIVE_STS_Q, 16'h0000);
        $display("test status done");
    endtask

    task automatic t_fault();
        setc(OP_COND_EN, 16'h0003, 1'b0);
        query(OP_ENABLED_Q, 16'h0003);
        pulse_live(16'h0006);
        check("fault pin set", 32'h0, {31'h0, fault_line_n});
        query(OP_FAULT_Q, 16'h0002);
        check("fault pin clr", 32'h1, {31'h0, fault_line_n});
        query(OP_FAULT_Q, 16'h0000);
        setc(OP_MASK, 16'h0002, 1'b0);
        query(OP_ENABLED_Q, 16'h0001);
        pulse_live(16'h0002);
        check("masked pin", 32'h1, {31'h0, fault_line_n});
        query(OP_FAULT_Q, 16'h0000);
        $display("test fault done");
    endtask

    task automatic t_restore();
        int c;
        logic [31:0] rd;
        setc(OP_AUX1_SET, ARG_ON, 1'b0);
        pulse_live(16'h0001);
        check("fault before", 32'h0, {31'h0, fault_line_n});
        c = apply_count;
        setc(OP_RESTORE, 16'h0000, 1'b0);
        repeat (2) @(posedge clock);
        check("apply pulse", c + 1, apply_count);
        check("fault cleared", 32'h1, {31'h0, fault_line_n});
        check("aux1 default", 32'h1, {31'h0, aux_one_n});
        query(OP_ENABLED_Q, 16'h0000);
        query(OP_CAL_Q, 16'h0001);
        local_mode <= 1'b1;
        setc(OP_AUX2_SET, ARG_ON, 1'b0);
        c = apply_count;
        setc(OP_RESTORE, 16'h0000, 1'b0);
        host.access(1'b0, OFS_STATE, WORD_ZERO, BE_ALL, rd);
        check("pending", 32'h1, {31'h0, rd[5]});
        check("aux2 held", 32'h0, {31'h0, aux_two_n});
        check("no apply", c, apply_count);
        local_mode <= 1'b0;
        for (int n = 0; n < 20 && apply_count == c; n++) @(posedge clock);
        repeat (2) @(posedge clock);
        check("late apply", c + 1, apply_count);
        check("aux2 default", 32'h1, {31'h0, aux_two_n});
        setc(OP_CAL_SET, ARG_OFF, 1'b0);
        query(OP_CAL_Q, 16'h0000);
        $display("test restore done");
    endtask

    task automatic t_refused();
        logic [31:0] rd;
        host.access(1'b0, 4'hC, WORD_ZERO, BE_ALL, rd);
        check("unmapped read", WORD_ZERO, rd);
        host.access(1'b1, OFS_CMD, 32'h0001_0007, 4'h3, rd);
        repeat (2) @(posedge clock);
        check("partial write", 32'h1, {31'h0, aux_one_n});
        host.access(1'b1, OFS_CMD, 32'h0000_000E, BE_ALL, rd);
        host.access(1'b0, OFS_RESP, WORD_ZERO, BE_ALL, rd);
        check("unknown op err", 32'h1, {31'h0, rd[8]});
        $display("test refused done");
    endtask

    task automatic print_verdict();
        check("bus hangs", 32'h0, host.hang_count);
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        reset_n     = 1'b0;
        status_live = STAT_ZERO;
        local_mode  = 1'b0;
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        t_reset();
        t_aux();
        t_cal();
        t_status();
        t_fault();
        t_restore();
        t_refused();
        print_verdict();
    end

    // Whole run is well under 2000 cycles
    initial begin
        #2000000;
        miscompares++;
        print_verdict();
    end
endmodule // testbench
